// file: core/bmx_shared_rx_mux.sv
// Shared receive and transmit bus logic of a four channel transceiver
`timescale 1ns/1ns
module bmx_shared_rx_mux #(
    parameter int NCH = bmx_pkg::NCH
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire bmx_pkg::bmx_chan_rx_type [NCH-1:0] chan_rx_in,
    input wire logic [NCH-1:0] rx_select_fast_in,
    input wire logic [NCH-1:0] rx_select_slow_in,
    output logic [3:0] shared_rx_nibble_out,
    output logic shared_rx_dv_out,
    output logic shared_rx_er_out,
    output logic shared_rx_clock_fast_out,
    output logic fast_bus_oe_n_out,
    output logic shared_rx_serial_out,
    output logic shared_rx_clock_slow_out,
    output logic slow_bus_oe_n_out,
    input wire logic tx_ref_clock_fast_in,
    input wire logic tx_ref_clock_slow_in,
    output logic shared_tx_clock_fast_out,
    output logic shared_tx_clock_slow_out,
    input wire bmx_pkg::bmx_tx_fast_type tx_fast_in,
    input wire bmx_pkg::bmx_tx_slow_type tx_slow_in,
    output bmx_pkg::bmx_tx_fast_type tx_fast_word_out,
    output logic tx_fast_strobe_out,
    output bmx_pkg::bmx_tx_slow_type tx_slow_word_out,
    output logic tx_slow_strobe_out,
    input wire logic [bmx_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [bmx_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [bmx_pkg::DATA_W-1:0] reg_rdata_out,
    output logic irq_out
);
    localparam int IW = bmx_pkg::IDX_W;

    // Two stage synchronisers for every pin input
    bmx_pkg::bmx_chan_rx_type [NCH-1:0] ch_s1_q, ch_s2_q;
    logic [NCH-1:0] fsel_s1_q, fsel_s2_q, ssel_s1_q, ssel_s2_q;
    logic [1:0] txclk_s1_q, txclk_s2_q;
    bmx_pkg::bmx_tx_fast_type txf_s1_q, txf_s2_q;
    bmx_pkg::bmx_tx_slow_type txs_s1_q, txs_s2_q;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_sync
            always_ff @(posedge clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ch_s1_q[g] <= '0;
                    ch_s2_q[g] <= '0;
                    fsel_s1_q[g] <= 1'b0;
                    fsel_s2_q[g] <= 1'b0;
                    ssel_s1_q[g] <= 1'b0;
                    ssel_s2_q[g] <= 1'b0;
                end else begin
                    ch_s1_q[g] <= chan_rx_in[g];
                    ch_s2_q[g] <= ch_s1_q[g];
                    fsel_s1_q[g] <= rx_select_fast_in[g];
                    fsel_s2_q[g] <= fsel_s1_q[g];
                    ssel_s1_q[g] <= rx_select_slow_in[g];
                    ssel_s2_q[g] <= ssel_s1_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            txclk_s1_q <= 2'h0;
            txclk_s2_q <= 2'h0;
            txf_s1_q <= '0;
            txf_s2_q <= '0;
            txs_s1_q <= '0;
            txs_s2_q <= '0;
        end else begin
            txclk_s1_q <= {tx_ref_clock_slow_in, tx_ref_clock_fast_in};
            txclk_s2_q <= txclk_s1_q;
            txf_s1_q <= tx_fast_in;
            txf_s2_q <= txf_s1_q;
            txs_s1_q <= tx_slow_in;
            txs_s2_q <= txs_s1_q;
        end
    end

    // Register file
    logic [31:0] cfg_q;
    logic [bmx_pkg::ST_W-1:0] status_q, mask_q, ev_set;
    logic [NCH-1:0] speed_fast;
    logic combined, rep_link, rep_packet;
    logic wr_cfg, wr_status, wr_mask;

    assign speed_fast = cfg_q[bmx_pkg::CFG_SPEED_LSB +: NCH];
    assign combined = cfg_q[bmx_pkg::CFG_COMBINED_BIT];
    assign rep_link = cfg_q[bmx_pkg::CFG_REP_LINK_BIT];
    assign rep_packet = cfg_q[bmx_pkg::CFG_REP_PACKET_BIT];
    assign wr_cfg = reg_wr_in && (reg_addr_in == bmx_pkg::ADDR_CONFIG);
    assign wr_status = reg_wr_in && (reg_addr_in == bmx_pkg::ADDR_STATUS);
    assign wr_mask = reg_wr_in && (reg_addr_in == bmx_pkg::ADDR_MASK);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cfg_q <= bmx_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= reg_wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mask_q <= bmx_pkg::ST_RESET;
        end else if (wr_mask) begin
            mask_q <= reg_wdata_in[bmx_pkg::ST_W-1:0];
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_q <= bmx_pkg::ST_RESET;
        end else begin
            status_q <= (status_q & ~(wr_status ? reg_wdata_in[bmx_pkg::ST_W-1:0] :
                bmx_pkg::ST_RESET)) | ev_set;
        end
    end

    assign irq_out = |(status_q & mask_q);

    // Requests per bus after speed and mode filtering
    logic [NCH-1:0] fast_req, slow_req;
    assign fast_req = fsel_s2_q & speed_fast;
    assign slow_req = combined ? (fsel_s2_q & ~speed_fast) : (ssel_s2_q & ~speed_fast);

    // Lowest requesting channel wins if the controller breaks the one-select rule
    logic [IW-1:0] fast_idx, slow_idx;
    always_comb begin
        fast_idx = '0;
        slow_idx = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (fast_req[i]) begin
                fast_idx = IW'(i);
            end
            if (slow_req[i]) begin
                slow_idx = IW'(i);
            end
        end
    end

    logic fast_act_q, slow_act_q;
    logic [IW-1:0] fast_ch_q, slow_ch_q;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fast_act_q <= 1'b0;
            slow_act_q <= 1'b0;
            fast_ch_q <= '0;
            slow_ch_q <= '0;
        end else begin
            fast_act_q <= |fast_req;
            slow_act_q <= |slow_req;
            fast_ch_q <= fast_idx;
            slow_ch_q <= slow_idx;
        end
    end

    assign fast_bus_oe_n_out = !fast_act_q;
    assign slow_bus_oe_n_out = !slow_act_q;

    // Clock edges of the selected channel
    bmx_pkg::bmx_chan_rx_type fch, sch;
    logic fclk_prev_q, sclk_prev_q, fall_fast, fall_slow;
    assign fch = ch_s2_q[fast_ch_q];
    assign sch = ch_s2_q[slow_ch_q];
    assign fall_fast = fclk_prev_q && !fch.clk_fast;
    assign fall_slow = sclk_prev_q && !sch.clk_slow;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fclk_prev_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            shared_rx_clock_fast_out <= 1'b0;
            shared_rx_clock_slow_out <= 1'b0;
        end else begin
            fclk_prev_q <= fch.clk_fast;
            sclk_prev_q <= sch.clk_slow;
            shared_rx_clock_fast_out <= fch.clk_fast;
            shared_rx_clock_slow_out <= sch.clk_slow;
        end
    end

    // Code of the highest enabled error flag wins over data while the error line is high
    function automatic logic [3:0] pick_nibble(input bmx_pkg::bmx_chan_rx_type c,
                                               input logic rl, input logic rp);
        logic [3:0] n;
        n = c.nibble;
        if (c.er) begin
            if (c.err_flags[bmx_pkg::EF_CODE]) begin
                n = bmx_pkg::ERR_CODE;
            end else if (c.err_flags[bmx_pkg::EF_PREMATURE]) begin
                n = bmx_pkg::ERR_PREMATURE;
            end else if (c.err_flags[bmx_pkg::EF_LINK] && rl) begin
                n = bmx_pkg::ERR_LINK;
            end else if (c.err_flags[bmx_pkg::EF_PACKET] && rp) begin
                n = bmx_pkg::ERR_PACKET;
            end
        end
        return n;
    endfunction

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shared_rx_nibble_out <= 4'h0;
        end else if (fast_act_q && fall_fast) begin
            shared_rx_nibble_out <= pick_nibble(fch, rep_link, rep_packet);
        end
    end

    // valid and error on the fast bus only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shared_rx_dv_out <= 1'b0;
            shared_rx_er_out <= 1'b0;
        end else if (!(|fast_req)) begin
            // Cleared with the ownership flag so valid never outlives the bus
            shared_rx_dv_out <= 1'b0;
            shared_rx_er_out <= 1'b0;
        end else if (fall_fast) begin
            shared_rx_dv_out <= fch.dv;
            shared_rx_er_out <= fch.er;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shared_rx_serial_out <= 1'b0;
        end else if (slow_act_q && fall_slow) begin
            shared_rx_serial_out <= sch.serial_bit;
        end
    end

    // Transmit side: clocks forwarded, inputs taken at rising edges
    logic [1:0] txclk_prev_q;
    logic rise_tx_fast, rise_tx_slow;
    assign rise_tx_fast = txclk_s2_q[0] && !txclk_prev_q[0];
    assign rise_tx_slow = txclk_s2_q[1] && !txclk_prev_q[1];

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            txclk_prev_q <= 2'h0;
            shared_tx_clock_fast_out <= 1'b0;
            shared_tx_clock_slow_out <= 1'b0;
        end else begin
            txclk_prev_q <= txclk_s2_q;
            shared_tx_clock_fast_out <= txclk_s2_q[0];
            shared_tx_clock_slow_out <= txclk_s2_q[1];
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_fast_word_out <= '0;
            tx_fast_strobe_out <= 1'b0;
        end else begin
            tx_fast_strobe_out <= rise_tx_fast;
            if (rise_tx_fast) begin
                tx_fast_word_out <= txf_s2_q;
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_slow_word_out <= '0;
            tx_slow_strobe_out <= 1'b0;
        end else begin
            tx_slow_strobe_out <= rise_tx_slow;
            if (rise_tx_slow) begin
                tx_slow_word_out <= txs_s2_q;
            end
        end
    end

    // Events; a second select flags the controller's breach of the one-select rule
    logic [NCH-1:0] all_fsel, all_ssel;
    assign all_fsel = fsel_s2_q;
    assign all_ssel = combined ? '0 : ssel_s2_q;
    always_comb begin
        ev_set = '0;
        ev_set[bmx_pkg::ST_CONFLICT] = ((all_fsel & (all_fsel - 1'b1)) != '0) ||
            ((all_ssel & (all_ssel - 1'b1)) != '0);
        ev_set[bmx_pkg::ST_RX_ERROR] = fast_act_q && fall_fast && fch.er;
        ev_set[bmx_pkg::ST_IGNORED] = (combined ? 1'b0 : |(ssel_s2_q & speed_fast)) ||
            (!combined && |(fsel_s2_q & ~speed_fast));
    end

    // Read data valid only in the cycle after the strobe
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (reg_addr_in)
            bmx_pkg::ADDR_CONFIG: rd_mux = cfg_q;
            bmx_pkg::ADDR_STATUS: rd_mux[bmx_pkg::ST_W-1:0] = status_q;
            bmx_pkg::ADDR_MASK: rd_mux[bmx_pkg::ST_W-1:0] = mask_q;
            bmx_pkg::ADDR_BUSSTATE: begin
                rd_mux[bmx_pkg::BS_FAST_ACT] = fast_act_q;
                rd_mux[bmx_pkg::BS_FAST_CH_LSB +: IW] = fast_ch_q;
                rd_mux[bmx_pkg::BS_SLOW_ACT] = slow_act_q;
                rd_mux[bmx_pkg::BS_SLOW_CH_LSB +: IW] = slow_ch_q;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 32'h0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0;
        end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    sequence fast_fall_s;
        fast_act_q && fall_fast;
    endsequence

    sequence tx_fast_rise_s;
        !txclk_prev_q[0] && txclk_s2_q[0];
    endsequence

    fast_float_a: assert property (!fast_act_q |-> fast_bus_oe_n_out && !shared_rx_dv_out)
        else $error("fast bus driven with no select");
    slow_float_a: assert property ($past(slow_req) == '0 |-> slow_bus_oe_n_out)
        else $error("serial bus driven with no select");
    nibble_edge_a: assert property (!$stable(shared_rx_nibble_out) |-> $past(fall_fast))
        else $error("nibble changed off falling edge");
    serial_edge_a: assert property (!$stable(shared_rx_serial_out) |-> $past(fall_slow))
        else $error("serial data changed off falling edge");
    code_err_a: assert property (fast_fall_s ##0 (fch.er && fch.err_flags[bmx_pkg::EF_CODE])
        |=> shared_rx_er_out && shared_rx_nibble_out == bmx_pkg::ERR_CODE)
        else $error("code error not shown as 5h");
    link_gate_a: assert property (shared_rx_er_out && shared_rx_nibble_out == bmx_pkg::ERR_LINK &&
        $stable(cfg_q) |-> rep_link)
        else $error("link code shown while disabled");
    fast_speed_a: assert property (fast_act_q && $stable(cfg_q) |-> speed_fast[fast_ch_q])
        else $error("fast bus given to slow channel");
    slow_speed_a: assert property (slow_act_q && $stable(cfg_q) |-> !speed_fast[slow_ch_q])
        else $error("serial bus given to fast channel");
    comb_ignore_a: assert property (combined && $past(combined) &&
        $past((fsel_s2_q & ~speed_fast) == '0) |-> !slow_act_q)
        else $error("slow select honoured in combined mode");
    tx_capture_a: assert property (tx_fast_rise_s |=> tx_fast_strobe_out ##1
        !tx_fast_strobe_out && tx_fast_word_out == $past(txf_s2_q, 2))
        else $error("fast transmit word not captured at rising edge");
endmodule

// file: core/bmx_pkg.sv
// Shared definitions for the bused receive multiplexer
package bmx_pkg;
    localparam int NCH = 4;
    localparam int NIB_W = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 2;

    // Register byte addresses
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_BUSSTATE = 8'h0c;

    // Config field positions
    localparam int CFG_SPEED_LSB = 0;
    localparam int CFG_COMBINED_BIT = 4;
    localparam int CFG_REP_LINK_BIT = 8;
    localparam int CFG_REP_PACKET_BIT = 9;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // Status and mask bits
    localparam int ST_W = 3;
    localparam int ST_CONFLICT = 0;
    localparam int ST_RX_ERROR = 1;
    localparam int ST_IGNORED = 2;
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;

    // Bus state read-back positions
    localparam int BS_FAST_ACT = 0;
    localparam int BS_FAST_CH_LSB = 1;
    localparam int BS_SLOW_ACT = 4;
    localparam int BS_SLOW_CH_LSB = 5;

    // Error codes shown on the nibble lines
    localparam logic [3:0] ERR_PACKET = 4'h2;
    localparam logic [3:0] ERR_LINK = 4'h3;
    localparam logic [3:0] ERR_PREMATURE = 4'h4;
    localparam logic [3:0] ERR_CODE = 4'h5;

    // Error flag positions within a channel's flags
    localparam int EF_PACKET = 0;
    localparam int EF_LINK = 1;
    localparam int EF_PREMATURE = 2;
    localparam int EF_CODE = 3;

    typedef struct packed {
        logic [3:0] nibble;
        logic dv;
        logic er;
        logic [3:0] err_flags;
        logic serial_bit;
        logic clk_fast;
        logic clk_slow;
    } bmx_chan_rx_type;

    typedef struct packed {
        logic en;
        logic er;
        logic [3:0] nibble;
    } bmx_tx_fast_type;

    typedef struct packed {
        logic en;
        logic bit_val;
    } bmx_tx_slow_type;
endpackage

// file: test/bmx_ctrl_model.sv
// Repeater controller model driving the shared transmit inputs
`timescale 1ns/1ns
module bmx_ctrl_model (
    input wire logic resetn_in,
    input wire logic shared_tx_clock_fast_in,
    input wire logic shared_tx_clock_slow_in,
    output bmx_pkg::bmx_tx_fast_type tx_fast_out,
    output bmx_pkg::bmx_tx_slow_type tx_slow_out
);
    logic [4:0] fast_cnt_q;
    logic slow_bit_q;

    always_ff @(negedge shared_tx_clock_fast_in or negedge resetn_in) begin
        if (!resetn_in) begin
            fast_cnt_q <= 5'h00;
        end else begin
            fast_cnt_q <= fast_cnt_q + 5'h03;
        end
    end

    // serial bit moves at falling edge
    always_ff @(negedge shared_tx_clock_slow_in or negedge resetn_in) begin
        if (!resetn_in) begin
            slow_bit_q <= 1'b0;
        end else begin
            slow_bit_q <= ~slow_bit_q;
        end
    end

    // Enable held high so every capture carries new data
    assign tx_fast_out = '{en: 1'b1, er: fast_cnt_q[4], nibble: fast_cnt_q[3:0]};
    assign tx_slow_out = '{en: 1'b1, bit_val: slow_bit_q};
endmodule

// file: test/testbench.sv
// Self-checking bench for the shared receive multiplexer
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic lclk = 1'b0;
    logic [3:0][3:0] nib = '0;
    logic [3:0][3:0] fl = '0;
    logic [3:0] dv = '0;
    logic [3:0] er = '0;
    logic [3:0] ser = '0;
    logic [3:0] sel_f = '0;
    logic [3:0] sel_s = '0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [3:0] s_nib;
    logic s_dv, s_er, s_cf, f_oe_n, s_ser, s_cs, s_oe_n, tcf, tcs, f_stb, s_stb, irq;
    bmx_pkg::bmx_chan_rx_type [3:0] chan;
    bmx_pkg::bmx_tx_fast_type tx_f, f_word;
    bmx_pkg::bmx_tx_slow_type tx_s, s_word;
    int error_cnt = 0;
    int comparisons = 0;
    int f_cnt = 0;
    int s_cnt = 0;
    logic [3:0] codes [4] = '{4'h2, 4'h3, 4'h4, 4'h5};

    always #20 clk_in = ~clk_in;
    // Link clocks share one source, offset from the system clock
    initial begin
        #7;
        forever #160 lclk = ~lclk;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chan[i] = '{nibble: nib[i], dv: dv[i], er: er[i], err_flags: fl[i],
                serial_bit: ser[i], clk_fast: lclk, clk_slow: lclk};
        end
    end

    bmx_shared_rx_mux bmx_shared_rx_mux_i (.clk_in(clk_in), .resetn_in(resetn_in),
        .chan_rx_in(chan), .rx_select_fast_in(sel_f), .rx_select_slow_in(sel_s),
        .shared_rx_nibble_out(s_nib), .shared_rx_dv_out(s_dv), .shared_rx_er_out(s_er),
        .shared_rx_clock_fast_out(s_cf), .fast_bus_oe_n_out(f_oe_n),
        .shared_rx_serial_out(s_ser), .shared_rx_clock_slow_out(s_cs),
        .slow_bus_oe_n_out(s_oe_n), .tx_ref_clock_fast_in(lclk), .tx_ref_clock_slow_in(lclk),
        .shared_tx_clock_fast_out(tcf), .shared_tx_clock_slow_out(tcs),
        .tx_fast_in(tx_f), .tx_slow_in(tx_s), .tx_fast_word_out(f_word),
        .tx_fast_strobe_out(f_stb), .tx_slow_word_out(s_word), .tx_slow_strobe_out(s_stb),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .irq_out(irq));

    bmx_ctrl_model bmx_ctrl_model_i (.resetn_in(resetn_in), .shared_tx_clock_fast_in(tcf),
        .shared_tx_clock_slow_in(tcs), .tx_fast_out(tx_f), .tx_slow_out(tx_s));

    always @(posedge clk_in) begin
        if (f_stb) begin
            f_cnt++;
            `CHK(f_word, tx_f)
        end
        if (s_stb) begin
            s_cnt++;
            `CHK(s_word, tx_s)
        end
    end

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask

    // Three link periods cover sync depth plus a falling edge
    task automatic settle(input logic [3:0] f, input logic [3:0] s);
        @(posedge clk_in);
        sel_f <= f;
        sel_s <= s;
        repeat (24) @(posedge clk_in);
        #1;
    endtask

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, error_cnt);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        `CHK(f_oe_n, 1'b1)
        `CHK(s_oe_n, 1'b1)
        chk_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0000);
        chk_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0000);
        chk_reg(bmx_pkg::ADDR_MASK, 32'h0000_0000);
        chk_reg(8'h10, 32'h0000_0000);
        wr_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0303);
        chk_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0303);
        done("registers");
        nib[1] <= 4'ha;
        dv[1] <= 1'b1;
        settle(4'b0010, 4'b0000);
        `CHK(f_oe_n, 1'b0)
        `CHK(s_nib, 4'ha)
        `CHK(s_dv, 1'b1)
        `CHK(s_er, 1'b0)
        chk_reg(bmx_pkg::ADDR_BUSSTATE, 32'h0000_0003);
        done("fast select");
        wr_reg(bmx_pkg::ADDR_MASK, 32'h0000_0002);
        er[1] <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            fl[1] <= 4'h1 << k;
            settle(4'b0010, 4'b0000);
            `CHK(s_nib, codes[k])
            `CHK(s_er, 1'b1)
        end
        `CHK(irq, 1'b1)
        wr_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0003);
        fl[1] <= 4'h2;
        settle(4'b0010, 4'b0000);
        `CHK(s_nib, 4'ha)
        fl[1] <= 4'h1;
        settle(4'b0010, 4'b0000);
        `CHK(s_nib, 4'ha)
        er[1] <= 1'b0;
        dv[1] <= 1'b0;
        settle(4'b0000, 4'b0000);
        `CHK(f_oe_n, 1'b1)
        `CHK(s_dv, 1'b0)
        wr_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0007);
        chk_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        done("error codes");
        ser[2] <= 1'b1;
        settle(4'b0000, 4'b0100);
        `CHK(s_oe_n, 1'b0)
        `CHK(s_ser, 1'b1)
        ser[2] <= 1'b0;
        settle(4'b0000, 4'b0100);
        `CHK(s_ser, 1'b0)
        chk_reg(bmx_pkg::ADDR_BUSSTATE, 32'h0000_0050);
        settle(4'b0000, 4'b0000);
        `CHK(s_oe_n, 1'b1)
        done("slow select");
        settle(4'b1000, 4'b0001);
        `CHK(f_oe_n, 1'b1)
        `CHK(s_oe_n, 1'b1)
        chk_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0004);
        settle(4'b0000, 4'b0000);
        wr_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0013);
        settle(4'b0000, 4'b0100);
        `CHK(s_oe_n, 1'b1)
        settle(4'b0100, 4'b0000);
        `CHK(s_oe_n, 1'b0)
        `CHK(f_oe_n, 1'b1)
        done("ignored and combined");
        settle(4'b0000, 4'b0000);
        wr_reg(bmx_pkg::ADDR_CONFIG, 32'h0000_0003);
        wr_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0007);
        settle(4'b0011, 4'b0000);
        chk_reg(bmx_pkg::ADDR_STATUS, 32'h0000_0001);
        chk_reg(bmx_pkg::ADDR_BUSSTATE, 32'h0000_0001);
        `CHK(f_cnt > 20, 1'b1)
        `CHK(s_cnt > 20, 1'b1)
        done("conflict and transmit");
        end_of_test();
    end
endmodule
